// ---- hw/fsf_fault_capture.v ----
// Registers ECC fault outcome of an array read one cycle after the read
`timescale 1ns/1ns
module fsf_fault_capture (
  input wire i_clk,
  input wire i_resetn,
  input wire i_rd,
  input wire i_sbe,
  input wire i_dbe,
  input wire i_collide,
  input wire i_ignore_single_fault,
  input wire i_force_d,
  input wire i_force_s,
  output reg o_set_d,
  output reg o_set_s
);
  reg set_d_nxt;
  reg set_s_nxt;
  always @* begin
    set_d_nxt = 1'b0;
    set_s_nxt = 1'b0;
    if (i_rd) begin
      if (i_collide) begin
        set_d_nxt = 1'b1;
        set_s_nxt = 1'b1;
      end else begin
        set_d_nxt = i_dbe;
        set_s_nxt = i_sbe & ~i_dbe & ~i_ignore_single_fault;
      end
      if (i_force_d)
        set_d_nxt = 1'b1;
      if (i_force_s)
        set_s_nxt = 1'b1;
    end
  end
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_set_d <= 1'b0;
      o_set_s <= 1'b0;
    end else begin
      o_set_d <= set_d_nxt;
      o_set_s <= set_s_nxt;
    end
  end
endmodule // fsf_fault_capture

// ---- hw/fsf_map.vh ----
// Register offsets, bit positions and reset values of the flash status block
`ifndef FSF_MAP_VH
`define FSF_MAP_VH
`define FSF_ADDR_W 4
`define FSF_OFS_CONFIG 4'h4
`define FSF_OFS_ERR_IRQ_CFG 4'h3
`define FSF_OFS_STATUS 4'h6
`define FSF_OFS_ERR_STATUS 4'h7
`define FSF_BIT_CMD_DONE 7
`define FSF_BIT_ACC_ERR 5
`define FSF_BIT_PROT_VIOL 4
`define FSF_BIT_BUSY 3
`define FSF_BIT_STAT_HI 1
`define FSF_BIT_STAT_LO 0
`define FSF_BIT_DFAULT 1
`define FSF_BIT_SFAULT 0
`define FSF_BIT_CMD_DONE_IRQ_ENABLE 7
`define FSF_BIT_IGNORE_SINGLE_FAULT 4
`define FSF_BIT_FORCE_DOUBLE_FAULT 1
`define FSF_BIT_FORCE_SINGLE_FAULT 0
`define FSF_BIT_DFIE 1
`define FSF_BIT_SFIE 0
`define FSF_RST_BYTE 8'h00
`define FSF_RST_STAT 2'h0
`define FSF_RST_DONE 1'b1
`define FSF_RST_FLAG 1'b0
`endif

// ---- hw/fsf_status_regs.v ----
// Flash status and error status registers with fault and command flags
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "fsf_map.vh"
// Overview of operation
// - Writing one to command-done launches command; flag returns high on finish or violation.
// - Access error flag sets on sequence violation or illegal command.
// - While access error set, command-done write neither clears nor launches.
// - Access error clears only by writing one.
// - Protection violation flag sets on program or erase to protected region.
// - Protection violation clears only by writing one.
// - While protection violation set, no launch and no new sequence start.
// - Busy reads one while a command executes, zero when idle.
// - Completion status bits set on command or reset-sequence error.
// - Only done, access and protection bits writable; others read-only or zero.
// - Status bit two always reads zero.
// - Status reset value may differ after double fault in reset sequence.
// - Double fault flag sets on double bit fault during array read.
// - Double fault flag clears by writing one only.
// - Single fault flag sets on single fault unless ignore bit set.
// - Single bit faults are corrected in the returned data.
// - Single fault flag clears by writing one only.
// - A genuine ECC fault sets at most one fault flag.
// - Read collision with busy block sets both fault flags.
// - Fault flags stored two cycles after the read.
// - Error status flags readable; writes only clear them.
// - Command-done interrupt requested while enabled and flag set.
// - Fault interrupts requested while enabled and matching flag set.
// - Force-double control makes every array read set double flag.
// - Force-single control makes every array read set single flag.
module fsf_status_regs (
  input wire i_clk,
  input wire i_resetn,
  input wire [`FSF_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_cmd_complete,
  input wire i_acc_err_set,
  input wire i_prot_viol_set,
  input wire [1:0] i_cmp_err,
  input wire i_cmp_err_valid,
  input wire i_reset_dfault,
  input wire i_arr_rd,
  input wire [7:0] i_arr_data,
  input wire [2:0] i_arr_sbe_pos,
  input wire i_arr_sbe,
  input wire i_arr_dbe,
  input wire i_arr_collide,
  output reg [7:0] o_arr_data,
  output wire o_cmd_launch,
  output wire o_seq_allowed,
  output wire o_busy,
  output wire o_cmd_irq,
  output wire o_err_irq
);
  // ***************************************
  // Functions
  // ***************************************
  function [7:0] bit_mask;
    input [2:0] pos;
    begin
      bit_mask = 8'h01 << pos;
    end
  endfunction
  function flag_next;
    input cur;
    input hw_set;
    input sw_clr;
    begin
      if (hw_set)
        flag_next = 1'b1;
      else if (sw_clr)
        flag_next = 1'b0;
      else
        flag_next = cur;
    end
  endfunction
  function reg_hit;
    input strobe;
    input [`FSF_ADDR_W-1:0] addr;
    input [`FSF_ADDR_W-1:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction
  // ***************************************
  // State
  // ***************************************
  reg cmd_done_r;
  reg acc_err_r;
  reg prot_viol_r;
  reg [1:0] cmp_stat_r;
  reg dfault_r;
  reg sfault_r;
  reg cmd_done_irq_enable_r;
  reg ignore_single_fault_r;
  reg force_double_fault_r;
  reg force_single_fault_r;
  reg dfie_r;
  reg sfie_r;
  reg cmd_done_nxt;
  reg acc_err_nxt;
  reg prot_viol_nxt;
  reg [1:0] cmp_stat_nxt;
  reg dfault_nxt;
  reg sfault_nxt;
  reg cmd_done_irq_enable_nxt;
  reg ignore_single_fault_nxt;
  reg force_double_fault_nxt;
  reg force_single_fault_nxt;
  reg dfie_nxt;
  reg sfie_nxt;
  reg [7:0] arr_data_nxt;
  reg [7:0] rdata_nxt;
  wire set_d;
  wire set_s;
  wire wr_stat;
  wire wr_err;
  wire wr_cfg;
  wire wr_ecfg;
  wire w1_done;
  wire w1_acc;
  wire w1_viol;
  wire w1_dfault;
  wire w1_sfault;
  // ***************************************
  // Address decode
  // ***************************************
  assign wr_stat = reg_hit(i_wr, i_addr, `FSF_OFS_STATUS);
  assign wr_err = reg_hit(i_wr, i_addr, `FSF_OFS_ERR_STATUS);
  assign wr_cfg = reg_hit(i_wr, i_addr, `FSF_OFS_CONFIG);
  assign wr_ecfg = reg_hit(i_wr, i_addr, `FSF_OFS_ERR_IRQ_CFG);
  // ***************************************
  // Clear and launch strobes
  // ***************************************
  assign w1_done = wr_stat && i_wdata[`FSF_BIT_CMD_DONE];
  assign w1_acc = wr_stat && i_wdata[`FSF_BIT_ACC_ERR];
  assign w1_viol = wr_stat && i_wdata[`FSF_BIT_PROT_VIOL];
  assign w1_dfault = wr_err && i_wdata[`FSF_BIT_DFAULT];
  assign w1_sfault = wr_err && i_wdata[`FSF_BIT_SFAULT];
  // ***************************************
  // Command launch
  // ***************************************
  // Access error blocks
  assign o_cmd_launch = w1_done && cmd_done_r && !acc_err_r && !prot_viol_r;
  assign o_seq_allowed = !prot_viol_r;
  assign o_busy = !cmd_done_r;
  // ***************************************
  // Fault capture
  // ***************************************
  fsf_fault_capture u_cap (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_rd(i_arr_rd),
    .i_sbe(i_arr_sbe),
    .i_dbe(i_arr_dbe),
    .i_collide(i_arr_collide),
    .i_ignore_single_fault(ignore_single_fault_r),
    .i_force_d(force_double_fault_r),
    .i_force_s(force_single_fault_r),
    .o_set_d(set_d),
    .o_set_s(set_s)
  );
  // ***************************************
  // Data correction
  // ***************************************
  always @* begin
    arr_data_nxt = i_arr_data;
    if (i_arr_sbe && !i_arr_dbe)
      arr_data_nxt = i_arr_data ^ bit_mask(i_arr_sbe_pos);
  end
  // ***************************************
  // Corrected data register
  // ***************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      o_arr_data <= `FSF_RST_BYTE;
    else if (i_arr_rd)
      o_arr_data <= arr_data_nxt;
  end
  // ***************************************
  // Status register
  // ***************************************
  always @* begin
    cmd_done_nxt = cmd_done_r;
    acc_err_nxt = acc_err_r;
    prot_viol_nxt = prot_viol_r;
    cmp_stat_nxt = cmp_stat_r;
    if (i_cmd_complete || i_prot_viol_set || i_acc_err_set)
      cmd_done_nxt = 1'b1;
    else if (o_cmd_launch)
      cmd_done_nxt = 1'b0;
    acc_err_nxt = flag_next(acc_err_r, i_acc_err_set, w1_acc);
    prot_viol_nxt = flag_next(prot_viol_r, i_prot_viol_set, w1_viol);
    if (i_reset_dfault)
      cmp_stat_nxt = {cmp_stat_r[`FSF_BIT_STAT_HI], 1'b1};
    else if (o_cmd_launch)
      cmp_stat_nxt = `FSF_RST_STAT;
    else if (i_cmp_err_valid)
      cmp_stat_nxt = cmp_stat_r | i_cmp_err;
  end
  // ***************************************
  // Status register update
  // ***************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_done_r <= `FSF_RST_DONE;
      acc_err_r <= `FSF_RST_FLAG;
      prot_viol_r <= `FSF_RST_FLAG;
      cmp_stat_r <= `FSF_RST_STAT;
    end else begin
      cmd_done_r <= cmd_done_nxt;
      acc_err_r <= acc_err_nxt;
      prot_viol_r <= prot_viol_nxt;
      cmp_stat_r <= cmp_stat_nxt;
    end
  end
  // ***************************************
  // Error status register
  // ***************************************
  always @* begin
    dfault_nxt = dfault_r;
    sfault_nxt = sfault_r;
    dfault_nxt = flag_next(dfault_r, set_d || i_reset_dfault, w1_dfault);
    sfault_nxt = flag_next(sfault_r, set_s, w1_sfault);
  end
  // ***************************************
  // Error status update
  // ***************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dfault_r <= `FSF_RST_FLAG;
      sfault_r <= `FSF_RST_FLAG;
    end else begin
      dfault_r <= dfault_nxt;
      sfault_r <= sfault_nxt;
    end
  end
  // ***************************************
  // Configuration registers
  // ***************************************
  always @* begin
    cmd_done_irq_enable_nxt = cmd_done_irq_enable_r;
    ignore_single_fault_nxt = ignore_single_fault_r;
    force_double_fault_nxt = force_double_fault_r;
    force_single_fault_nxt = force_single_fault_r;
    dfie_nxt = dfie_r;
    sfie_nxt = sfie_r;
    if (wr_cfg) begin
      cmd_done_irq_enable_nxt = i_wdata[`FSF_BIT_CMD_DONE_IRQ_ENABLE];
      ignore_single_fault_nxt = i_wdata[`FSF_BIT_IGNORE_SINGLE_FAULT];
      force_double_fault_nxt = i_wdata[`FSF_BIT_FORCE_DOUBLE_FAULT];
      force_single_fault_nxt = i_wdata[`FSF_BIT_FORCE_SINGLE_FAULT];
    end
    if (wr_ecfg) begin
      dfie_nxt = i_wdata[`FSF_BIT_DFIE];
      sfie_nxt = i_wdata[`FSF_BIT_SFIE];
    end
  end
  // ***************************************
  // Configuration update
  // ***************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_done_irq_enable_r <= `FSF_RST_FLAG;
      ignore_single_fault_r <= `FSF_RST_FLAG;
      force_double_fault_r <= `FSF_RST_FLAG;
      force_single_fault_r <= `FSF_RST_FLAG;
      dfie_r <= `FSF_RST_FLAG;
      sfie_r <= `FSF_RST_FLAG;
    end else begin
      cmd_done_irq_enable_r <= cmd_done_irq_enable_nxt;
      ignore_single_fault_r <= ignore_single_fault_nxt;
      force_double_fault_r <= force_double_fault_nxt;
      force_single_fault_r <= force_single_fault_nxt;
      dfie_r <= dfie_nxt;
      sfie_r <= sfie_nxt;
    end
  end
  // ***************************************
  // Interrupt requests
  // ***************************************
  // Command done request
  assign o_cmd_irq = cmd_done_irq_enable_r && cmd_done_r;
  assign o_err_irq = (dfie_r && dfault_r) || (sfie_r && sfault_r);
  // ***************************************
  // Read path
  // ***************************************
  always @* begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `FSF_OFS_STATUS: begin
        rdata_nxt[`FSF_BIT_CMD_DONE] = cmd_done_r;
        rdata_nxt[`FSF_BIT_ACC_ERR] = acc_err_r;
        rdata_nxt[`FSF_BIT_PROT_VIOL] = prot_viol_r;
        rdata_nxt[`FSF_BIT_BUSY] = o_busy;
        rdata_nxt[`FSF_BIT_STAT_HI:`FSF_BIT_STAT_LO] = cmp_stat_r;
      end
      `FSF_OFS_ERR_STATUS: begin
        rdata_nxt[`FSF_BIT_DFAULT] = dfault_r;
        rdata_nxt[`FSF_BIT_SFAULT] = sfault_r;
      end
      `FSF_OFS_CONFIG: begin
        rdata_nxt[`FSF_BIT_CMD_DONE_IRQ_ENABLE] = cmd_done_irq_enable_r;
        rdata_nxt[`FSF_BIT_IGNORE_SINGLE_FAULT] = ignore_single_fault_r;
        rdata_nxt[`FSF_BIT_FORCE_DOUBLE_FAULT] = force_double_fault_r;
        rdata_nxt[`FSF_BIT_FORCE_SINGLE_FAULT] = force_single_fault_r;
      end
      `FSF_OFS_ERR_IRQ_CFG: begin
        rdata_nxt[`FSF_BIT_DFIE] = dfie_r;
        rdata_nxt[`FSF_BIT_SFIE] = sfie_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end
  // ***************************************
  // Read data register
  // ***************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      o_rdata <= `FSF_RST_BYTE;
    else if (i_rd)
      o_rdata <= rdata_nxt;
  end
endmodule // fsf_status_regs

// ---- sim/flash_status_error_flags_tb.sv ----
// Self-checking bench for the flash status block
`timescale 1ns/1ns
module flash_status_error_flags_tb;
  reg i_clk = 0;
  reg i_resetn = 0;
  reg [3:0] i_addr = 0;
  reg [7:0] i_wdata = 0;
  reg i_wr = 0;
  reg i_rd = 0;
  reg [4:0] ev = 0;
  reg [1:0] i_cmp_err = 0;
  reg [3:0] ar = 0;
  reg [7:0] i_arr_data = 0;
  reg [2:0] i_arr_sbe_pos = 0;
  reg [7:0] e;
  wire [7:0] o_rdata, o_arr_data;
  wire o_cmd_launch, o_seq_allowed, o_busy, o_cmd_irq, o_err_irq;
  integer num_errors = 0, n_checks = 0, cyc = 0, k, j, ig;
  fsf_status_regs DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmd_complete(ev[0]), .i_acc_err_set(ev[1]), .i_prot_viol_set(ev[2]),
    .i_cmp_err(i_cmp_err), .i_cmp_err_valid(ev[3]), .i_reset_dfault(ev[4]),
    .i_arr_rd(ar[0]), .i_arr_data(i_arr_data), .i_arr_sbe_pos(i_arr_sbe_pos),
    .i_arr_sbe(ar[1]), .i_arr_dbe(ar[2]), .i_arr_collide(ar[3]),
    .o_arr_data(o_arr_data), .o_cmd_launch(o_cmd_launch), .o_seq_allowed(o_seq_allowed),
    .o_busy(o_busy), .o_cmd_irq(o_cmd_irq), .o_err_irq(o_err_irq));
  // ****
  // Bus and event tasks
  // ****
  task chk(input [7:0] s, input [7:0] x);
    begin
      n_checks = n_checks + 1;
      if (s !== x) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk) i_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, input [7:0] x);
    begin
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk) i_rd <= 1'b0;
      #1 chk(o_rdata, x);
    end
  endtask
  task pulse(input [4:0] m);
    begin
      @(posedge i_clk) ev <= m;
      @(posedge i_clk) ev <= 5'h00;
      #1;
    end
  endtask
  task arr(input [3:0] m);
    begin
      @(posedge i_clk);
      ar <= m;
      i_arr_data <= $urandom;
      i_arr_sbe_pos <= $urandom;
      @(posedge i_clk) ar <= 4'h0;
      #1;
    end
  endtask
  function [7:0] exp_fault(input integer kind, input integer ign);
    begin
      if (kind == 3) exp_fault = 8'h03;
      else if (kind == 2) exp_fault = 8'h02;
      else if (kind == 1) exp_fault = (ign != 0) ? 8'h00 : 8'h01;
      else exp_fault = 8'h00;
    end
  endfunction
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // ****
  // Clock, timeout and tests
  // ****
  initial forever #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  initial begin
    k = $urandom(74283);
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(4'h6, 8'h80);
    rd(4'h7, 8'h00);
    rd(4'h5, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h4, 8'h80);
    wr(4'h3, 8'h03);
    chk(o_cmd_irq, 1);
    wr(4'h6, 8'h80);
    chk(o_cmd_irq, 0);
    rd(4'h6, 8'h08);
    pulse(5'h01);
    rd(4'h6, 8'h80);
    wr(4'h6, 8'h7F);
    rd(4'h6, 8'h80);
    $display("command test done");
    for (k = 0; k < 2; k = k + 1) begin
      e = 8'h20 >> k;
      wr(4'h6, 8'h80);
      pulse(5'h02 << k);
      chk(o_seq_allowed, k == 0);
      rd(4'h6, 8'h80 | e);
      wr(4'h6, 8'h80);
      rd(4'h6, 8'h80 | e);
      wr(4'h6, 8'h00);
      rd(4'h6, 8'h80 | e);
      wr(4'h6, e);
      rd(4'h6, 8'h80);
    end
    $display("error flag test done");
    for (k = 1; k < 4; k = k + 1) begin
      wr(4'h6, 8'h80);
      i_cmp_err <= k[1:0];
      pulse(5'h09);
      rd(4'h6, 8'h80 | k[7:0]);
      wr(4'h6, 8'h03);
      rd(4'h6, 8'h80 | k[7:0]);
    end
    wr(4'h6, 8'h80);
    pulse(5'h01);
    pulse(5'h10);
    rd(4'h6, 8'h81);
    rd(4'h7, 8'h02);
    wr(4'h7, 8'h03);
    $display("completion test done");
    for (j = 0; j < 24; j = j + 1) begin
      k = (j < 4) ? j : $urandom % 4;
      ig = $urandom % 2;
      wr(4'h4, ig << 4);
      arr((1 << k) | 1);
      if (k < 2) chk(o_arr_data, i_arr_data ^ (k << i_arr_sbe_pos));
      e = exp_fault(k, ig);
      rd(4'h7, e);
      chk(o_err_irq, e != 0);
      wr(4'h7, 8'h00);
      rd(4'h7, e);
      wr(4'h7, 8'h03);
      rd(4'h7, 8'h00);
    end
    wr(4'h4, 8'h03);
    arr(4'h1);
    rd(4'h7, 8'h03);
    wr(4'h7, 8'h03);
    wr(4'h4, 8'h00);
    @(posedge i_clk) ar <= 4'h5;
    @(posedge i_clk) ar <= 4'h0;
    i_addr <= 4'h7;
    i_wdata <= 8'h02;
    i_wr <= 1'b1;
    @(posedge i_clk) i_wr <= 1'b0;
    rd(4'h7, 8'h02);
    $display("fault test done");
    print_verdict;
  end
endmodule // flash_status_error_flags_tb

// ---- sim/fsf_status_asserts.sv ----
// Port assertions for the flash status block
`timescale 1ns/1ns
module fsf_status_asserts (
  input wire i_clk,
  input wire i_resetn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_cmd_complete,
  input wire i_acc_err_set,
  input wire i_prot_viol_set,
  input wire i_arr_rd,
  input wire [7:0] i_arr_data,
  input wire [2:0] i_arr_sbe_pos,
  input wire i_arr_sbe,
  input wire i_arr_dbe,
  input wire i_arr_collide,
  input wire [7:0] o_arr_data,
  input wire o_cmd_launch,
  input wire o_seq_allowed,
  input wire o_busy,
  input wire o_cmd_irq
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_dbe_rd;
    i_arr_rd && i_arr_dbe ##2 i_rd && i_addr == 4'h7;
  endsequence
  a_launch_cause: assert property (o_cmd_launch |->
    i_wr && i_addr == 4'h6 && i_wdata[7] && !o_busy && o_seq_allowed) else $error("bad launch");
  a_launch_busy: assert property (o_cmd_launch && !i_cmd_complete && !i_acc_err_set
    && !i_prot_viol_set |=> o_busy) else $error("no busy");
  a_busy_holds: assert property (o_busy && !i_cmd_complete && !i_acc_err_set
    && !i_prot_viol_set |=> o_busy) else $error("busy dropped");
  a_done_sets: assert property (o_busy && i_cmd_complete |=> !o_busy) else $error("no done");
  a_viol_blocks: assert property (i_prot_viol_set |=> !o_seq_allowed && !o_busy)
    else $error("violation not held");
  a_irq_done: assert property (o_cmd_irq |-> !o_busy) else $error("irq while busy");
  a_rsvd_zero: assert property (i_rd && i_addr == 4'h6 |=> !o_rdata[2]) else $error("bit2");
  a_unmapped_zero: assert property (i_rd && i_addr != 4'h3 && i_addr != 4'h4
    && i_addr != 4'h6 && i_addr != 4'h7 |=> o_rdata == 8'h00) else $error("unmapped");
  a_dbe_seen: assert property (s_dbe_rd |=> o_rdata[1]) else $error("no double flag");
  a_sbe_fix: assert property (i_arr_rd && i_arr_sbe && !i_arr_dbe && !i_arr_collide |=>
    o_arr_data == ($past(i_arr_data) ^ (8'h01 << $past(i_arr_sbe_pos)))) else $error("fix");
endmodule // fsf_status_asserts
bind fsf_status_regs fsf_status_asserts u_chk (.*);
